// ---- logic/pipelined_sync_sram_port.sv ----
// Control and data path of a pipelined synchronous SRAM bus port
`timescale 1ns/1ps
`default_nettype none

`include "sram_port_regs.svh"

// Overview of operation
// RULE1 - Register all synchronous inputs on rising edge
// RULE2 - Step burst counter when advance sampled low
// RULE3 - Selected only for low, high, low enables
// RULE4 - Enables sampled only when address loads
// RULE5 - Processor strobe ignored while first enable high
// RULE6 - Accepted strobe loads address and counter seed
// RULE7 - Processor strobe wins over controller strobe
// RULE8 - Advance low moves to next burst address
// RULE9 - Output enable gates data pins combinationally
// RULE10 - First read cycle after deselect stays floating
// RULE11 - Read data appears one cycle later
// RULE12 - Input data and parity registered on edge
// RULE13 - Sleep input idles port, keeps contents
// RULE14 - Sleep held low for normal operation
// RULE15 - Two-bit counter seeded from low address
// RULE16 - Static strap picks linear or interleaved
// RULE17 - Global write writes every byte
// RULE18 - Counter wraps; linear adds, interleaved XORs
// RULE19 - Master keeps output enable high when writing
module pipelined_sync_sram_port #(
  parameter int ADDR_W = `SRAM_DEF_ADDR_W,
  parameter int DATA_W = `SRAM_DEF_DATA_W,
  parameter int BYTES  = `SRAM_DEF_BYTES
) (
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              select_first_n_i,
  input  wire logic              select_second_high_i,
  input  wire logic              select_third_n_i,
  input  wire logic              processor_addr_strobe_n_i,
  input  wire logic              controller_addr_strobe_n_i,
  input  wire logic              burst_advance_n_i,
  input  wire logic              global_write_n_i,
  input  wire logic              byte_write_enable_n_i,
  input  wire logic [BYTES-1:0]  byte_select_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              sleep_request_i,
  input  wire logic              burst_order_i,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic [BYTES-1:0]  parity_lines_i,
  output logic [DATA_W-1:0]      data_o,
  output logic [BYTES-1:0]       parity_lines_o,
  output logic                   data_oe_o,
  output logic [ADDR_W-1:0]      mem_rd_addr_o,
  output logic                   mem_rd_en_o,
  input  wire logic [DATA_W-1:0] mem_rd_data_i,
  input  wire logic [BYTES-1:0]  mem_rd_parity_i,
  output logic                   mem_wr_valid_o,
  input  wire logic              mem_wr_ready_i,
  output logic [ADDR_W-1:0]      mem_wr_addr_o,
  output logic [DATA_W-1:0]      mem_wr_data_o,
  output logic [BYTES-1:0]       mem_wr_parity_o,
  output logic [BYTES-1:0]       mem_wr_mask_o,
  output logic                   wr_buf_ready_o,
  output logic                   sleeping_o
);
  import sram_port_pkg::*;

  localparam int ENTRY_W = ADDR_W + DATA_W + 2 * BYTES;

  // Sampled bus pins, one register stage
  logic [ADDR_W-1:0] s_addr;
  logic              s_sel1_n;
  logic              s_sel2;
  logic              s_sel3_n;
  logic              s_processor_addr_strobe_n_n;
  logic              s_controller_addr_strobe_n_n;
  logic              s_adv_n;
  logic              s_gw_n;
  logic              s_bwe_n;
  logic [BYTES-1:0]  s_bw_n;
  logic [DATA_W-1:0] s_data;
  logic [BYTES-1:0]  s_parity;

  // Sleep and strap synchronisers
  logic              sleep_meta;   // First stage, read only by sleep_sync
  logic              sleep_sync;   // Usable sleep level
  logic              order_meta;   // First stage, read only by order_sync
  logic              order_sync;
  logic [1:0]        order_wait;   // Edges until the strap has crossed both flops
  logic              interleave;   // Held burst order

  // Burst state
  port_state_t       state;
  port_state_t       next_state;
  logic [ADDR_W-1:0] base_addr;    // Address register
  logic [ADDR_W-1:0] next_base_addr;
  logic [1:0]        start_low;    // Counter seed
  logic [1:0]        next_start_low;
  logic [1:0]        seq;          // Burst counter
  logic [1:0]        next_seq;

  // Access decode
  logic              take_p;
  logic              take_c;
  logic              load;
  logic              chosen;
  logic [BYTES-1:0]  wr_mask;
  logic              wr_req;
  logic              access;
  logic              acc_write;
  logic              read_acc;
  logic [1:0]        acc_low;
  logic [ADDR_W-1:0] acc_addr;

  // Output stage
  logic                    out_drive;
  logic                    next_out_drive;
  logic [DATA_W+BYTES-1:0] out_word;
  logic [DATA_W+BYTES-1:0] next_out_word;

  wbuf_if #(.WIDTH(ENTRY_W)) wr_link ();

  // Address of position n within the burst, in the strapped order
  function automatic logic [1:0] burst_pos(input logic order, input logic [1:0] base, input logic [1:0] n);
    burst_pos = (order == `SRAM_ORDER_INTERLEAV) ? (base ^ n) : 2'(base + n); // see RULE18
  endfunction

  // Input register stage; strobes reset to their idle level
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_addr   <= '0;
      s_sel1_n <= 1'b1;
      s_sel2   <= 1'b0;
      s_sel3_n <= 1'b1;
      s_processor_addr_strobe_n_n <= 1'b1;
      s_controller_addr_strobe_n_n <= 1'b1;
      s_adv_n  <= 1'b1;
      s_gw_n   <= 1'b1;
      s_bwe_n  <= 1'b1;
      s_bw_n   <= '1;
      s_data   <= '0;
      s_parity <= '0;
    end
    else
    begin
      s_addr   <= addr_i;                    // see RULE1
      s_sel1_n <= select_first_n_i;
      s_sel2   <= select_second_high_i;
      s_sel3_n <= select_third_n_i;
      s_processor_addr_strobe_n_n <= processor_addr_strobe_n_i;
      s_controller_addr_strobe_n_n <= controller_addr_strobe_n_i;
      s_adv_n  <= burst_advance_n_i;
      s_gw_n   <= global_write_n_i;
      s_bwe_n  <= byte_write_enable_n_i;
      s_bw_n   <= byte_select_n_i;
      s_data   <= data_i;                    // see RULE12
      s_parity <= parity_lines_i;
    end
  end

  // Asynchronous sleep and strap pins pass two flops first
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sleep_meta  <= 1'b0;
      sleep_sync  <= 1'b0;
      order_meta  <= `SRAM_ORDER_INTERLEAV;
      order_sync  <= `SRAM_ORDER_INTERLEAV;
      order_wait  <= 2'h0;
      interleave  <= `SRAM_ORDER_INTERLEAV;
    end
    else
    begin
      sleep_meta <= sleep_request_i;         // see RULE13
      sleep_sync <= sleep_meta;
      order_meta <= burst_order_i;
      order_sync <= order_meta;
      // The strap is static: taken once both flops hold it, later wiggles are ignored
      if (order_wait != 2'h3)
      begin
        order_wait <= 2'(order_wait + 2'h1);
        interleave <= order_sync;            // see RULE16
      end
    end
  end

  // Strobe qualification, selection and burst stepping
  always_comb
  begin
    take_p  = !s_processor_addr_strobe_n_n && !s_sel1_n;                        // see RULE5
    take_c  = !s_controller_addr_strobe_n_n && !take_p;                          // see RULE7
    load    = (take_p || take_c) && !sleep_sync;
    chosen  = !s_sel1_n && s_sel2 && !s_sel3_n;              // see RULE3
    // Global write overrides the byte controls
    if (!s_gw_n)
    begin
      wr_mask = '1;                                          // see RULE17
    end
    else if (!s_bwe_n)
    begin
      wr_mask = ~s_bw_n;
    end
    else
    begin
      wr_mask = '0;
    end
    wr_req         = |wr_mask;
    next_state     = state;
    next_base_addr = base_addr;
    next_start_low = start_low;
    next_seq       = seq;
    access         = 1'b0;
    acc_write      = 1'b0;
    acc_low        = burst_pos(interleave, start_low, seq);
    acc_addr       = {base_addr[ADDR_W-1:2], acc_low};
    if (sleep_sync)
    begin
      // Sleep drops any burst; stored words stay untouched
      next_state = ST_ASLEEP;                                // see RULE13
    end
    else if (load)
    begin
      // Enables only count on a load edge
      if (chosen)                                            // see RULE4
      begin
        next_state     = ST_BURST;
        next_base_addr = s_addr;                             // see RULE6
        next_start_low = s_addr[1:0];                        // see RULE15
        next_seq       = `SRAM_SEQ_START;
        access         = 1'b1;
        acc_addr       = s_addr;
        // The processor strobe ignores write controls on its first edge
        acc_write      = take_c && wr_req;
      end
      else
      begin
        next_state = ST_DESEL;
      end
    end
    else if (state == ST_ASLEEP)
    begin
      next_state = ST_DESEL;
    end
    else if (state == ST_BURST)
    begin
      access    = 1'b1;
      acc_write = wr_req;
      if (!s_adv_n)
      begin
        next_seq = 2'(seq + `SRAM_SEQ_STEP);                 // see RULE2
        acc_low  = burst_pos(interleave, start_low, next_seq); // see RULE8
        acc_addr = {base_addr[ADDR_W-1:2], acc_low};
      end
    end
    read_acc = access && !acc_write;
  end

  // Burst state registers
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state     <= ST_DESEL;
      base_addr <= '0;
      start_low <= 2'h0;
      seq       <= 2'h0;
    end
    else
    begin
      state     <= next_state;
      base_addr <= next_base_addr;
      start_low <= next_start_low;
      seq       <= next_seq;
    end
  end

  // Read launch toward the array; its data must settle within this cycle
  assign mem_rd_addr_o = acc_addr;
  assign mem_rd_en_o   = read_acc;

  // Writes go through the two-entry buffer; valid ignores ready, so a write offered while the buffer is full is dropped
  assign wr_link.valid  = access && acc_write;
  assign wr_link.data   = {acc_addr, s_data, s_parity, wr_mask};
  assign wr_buf_ready_o = wr_link.ready;

  write_buffer #(
    .WIDTH (ENTRY_W)
  ) u_write_buffer (
    .core_clk_i    (core_clk_i),
    .arst_n_i      (arst_n_i),
    .fill_if       (wr_link),
    .drain_valid_o (mem_wr_valid_o),
    .drain_ready_i (mem_wr_ready_i),
    .drain_data_o  ({mem_wr_addr_o, mem_wr_data_o, mem_wr_parity_o, mem_wr_mask_o})
  );

  // Output register: only read cycles arm the drivers
  always_comb
  begin
    next_out_drive = read_acc;                               // see RULE10
    next_out_word  = out_word;
    if (read_acc)
    begin
      next_out_word = {mem_rd_data_i, mem_rd_parity_i};      // see RULE11
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      out_drive <= 1'b0;
      out_word  <= '0;
    end
    else
    begin
      out_drive <= next_out_drive;
      out_word  <= next_out_word;
    end
  end

  // Enable is unclocked by design; a detected write forces float regardless
  assign data_oe_o      = !output_enable_n_i && out_drive && !(access && acc_write); // see RULE9
  assign data_o         = out_word[DATA_W+BYTES-1:BYTES];
  assign parity_lines_o = out_word[BYTES-1:0];
  assign sleeping_o     = (state == ST_ASLEEP);              // see RULE14

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence rd_issue;
    read_acc;
  endsequence

  sequence rd_shown;
    out_drive && (out_word == $past({mem_rd_data_i, mem_rd_parity_i}));
  endsequence

  sequence desel_load;
    load && !chosen;
  endsequence

  read_latency_a : assert property (rd_issue |=> rd_shown) // see RULE11
    else $error("read data not presented one cycle after access");
  desel_float_a : assert property (desel_load |=> (!data_oe_o && !out_drive)) // see RULE10
    else $error("drivers on after deselect");
  oe_gate_a : assert property (output_enable_n_i |-> !data_oe_o) // see RULE9
    else $error("drivers on while output enable high");
  processor_addr_strobe_n_ignore_a : assert property ((s_sel1_n && s_controller_addr_strobe_n_n) |-> !load) // see RULE5
    else $error("access started from ignored processor strobe");
  seed_load_a : assert property ((load && chosen) |=> (seq == 2'h0 && start_low == $past(s_addr[1:0]))) // see RULE6
    else $error("counter not seeded from low address bits");
  strobe_prio_a : assert property ((!s_processor_addr_strobe_n_n && !s_sel1_n && !sleep_sync && chosen) |-> !acc_write) // see RULE7
    else $error("controller strobe write taken beside processor strobe");
  burst_hold_a : assert property ((state == ST_BURST && !load && !sleep_sync && s_adv_n) |=> $stable(seq)) // see RULE2
    else $error("burst counter moved without advance");
  burst_step_a : assert property ((state == ST_BURST && !load && !sleep_sync && !s_adv_n) |=>
    (seq == 2'($past(seq) + 2'h1))) // see RULE8
    else $error("burst counter did not step on advance");
  global_all_a : assert property (!s_gw_n |-> (wr_mask == {BYTES{1'b1}})) // see RULE17
    else $error("global write did not select every byte");
  sleep_quiet_a : assert property (sleep_sync |=> (!data_oe_o && !access) [*2]) // see RULE13
    else $error("port active during sleep");

endmodule

`default_nettype wire

// ---- include/sram_port_regs.svh ----
// Constants for the pipelined synchronous SRAM bus port
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

`define SRAM_DEF_ADDR_W      21
`define SRAM_DEF_DATA_W      32
`define SRAM_DEF_BYTES       4
`define SRAM_BURST_W         2
`define SRAM_BUF_DEPTH       2
`define SRAM_ORDER_LINEAR    1'b0
`define SRAM_ORDER_INTERLEAV 1'b1
`define SRAM_SEQ_START       2'h0
`define SRAM_SEQ_STEP        2'h1

`endif

// ---- include/sram_port_pkg.sv ----
// Types shared by the SRAM bus port modules
package sram_port_pkg;

  // Port state, one-hot
  typedef enum logic [2:0]
  {
    ST_DESEL  = 3'b001,
    ST_BURST  = 3'b010,
    ST_ASLEEP = 3'b100
  } port_state_t;

endpackage

// ---- include/wbuf_if.sv ----
// Valid/ready carrier between the port core and its write buffer
`timescale 1ns/1ps
`default_nettype none

interface wbuf_if #(
  parameter int WIDTH = 8
);
  logic             valid; // Entry offered
  logic             ready; // Entry can be taken
  logic [WIDTH-1:0] data;  // Packed write entry

  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- logic/write_buffer.sv ----
// Two-entry write buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

`include "sram_port_regs.svh"

module write_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  wbuf_if.consumer              fill_if,
  output logic                  drain_valid_o,
  input  wire logic             drain_ready_i,
  output logic [WIDTH-1:0]      drain_data_o
);
  import sram_port_pkg::*;

  logic [WIDTH-1:0] slot [`SRAM_BUF_DEPTH]; // Storage, two words
  logic             wr_ptr;                 // Next slot to fill
  logic             rd_ptr;                 // Next slot to drain
  logic [1:0]       count;                  // Words held
  logic             next_wr_ptr;
  logic             next_rd_ptr;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  // Ready only while a slot is free, so the producer sees real back-pressure
  assign fill_if.ready = (count != 2'(`SRAM_BUF_DEPTH));
  assign drain_valid_o = (count != 2'h0);
  assign drain_data_o  = slot[rd_ptr];

  // Pointer and level update
  always_comb
  begin
    push        = fill_if.valid && fill_if.ready;
    pop         = drain_valid_o && drain_ready_i;
    next_wr_ptr = push ? !wr_ptr : wr_ptr;
    next_rd_ptr = pop ? !rd_ptr : rd_ptr;
    next_count  = count;
    if (push && !pop)
    begin
      next_count = count + 2'h1;
    end
    else if (pop && !push)
    begin
      next_count = count - 2'h1;
    end
  end

  // Registers only; storage has no reset since valid gates it
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      slot[wr_ptr] <= fill_if.data;
    end
  end

  // A stalled drain must keep its word until taken
  drain_hold_a : assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (drain_valid_o && !drain_ready_i) |=> (drain_valid_o && $stable(drain_data_o)))
    else $error("buffered write changed while stalled");

endmodule

`default_nettype wire

// ---- verif/sram_array_model.sv ----
// Behavioural memory array behind the port: same-cycle read, stallable write sink
`timescale 1ns/1ps
`default_nettype none

module sram_array_model (
  input  wire logic        core_clk_i,
  input  wire logic [20:0] rd_addr_i,
  input  wire logic        rd_en_i,
  output logic [31:0]      rd_data_o,
  output logic [3:0]       rd_parity_o,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  input  wire logic [20:0] wr_addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic [3:0]  wr_parity_i,
  input  wire logic [3:0]  wr_mask_i,
  input  wire logic        stall_i
);
  logic [31:0] words [64]; // Only 64 locations modelled; upper address bits alias
  logic [3:0]  pars  [64]; // One parity bit per byte

  // Known contents so every read has a predictable value
  initial
  begin
    for (int i = 0; i < 64; i++)
    begin
      words[i] = {16'hC0DE, 10'h000, i[5:0]};
      pars[i]  = i[3:0];
    end
  end

  // Unselected reads show inverted data, so stale values never look right
  assign rd_data_o   = rd_en_i ? words[rd_addr_i[5:0]] : ~words[rd_addr_i[5:0]];
  assign rd_parity_o = rd_en_i ? pars[rd_addr_i[5:0]] : ~pars[rd_addr_i[5:0]];
  assign wr_ready_o  = !stall_i; // Stall lets the bench fill the write buffer

  // Masked byte write when an entry is taken
  always @(posedge core_clk_i)
  begin
    if (wr_valid_i && wr_ready_o)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wr_mask_i[b])
        begin
          words[wr_addr_i[5:0]][8*b +: 8] <= wr_data_i[8*b +: 8];
          pars[wr_addr_i[5:0]][b]         <= wr_parity_i[b];
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench of the pipelined synchronous SRAM bus port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        core_clk_i, arst_n_i, ce1_n, ce2, ce3_n, ps_n, cs_n, adv_n, gw_n, bwe_n, oe_n, sleep, order, stall;
  logic [20:0] addr, rd_addr, wr_addr;
  logic [31:0] wdata, data_o, rd_data, wr_data;
  logic [3:0]  bsel_n, wpar, par_o, rd_par, wr_par, wr_mask;
  logic        data_oe, rd_en, wr_valid, wr_ready, buf_ready, sleeping;
  int          err_count, total_checks;
  localparam logic [31:0] D1 = 32'h1234ABCD; // First write word
  localparam logic [31:0] D2 = 32'h8899EEFF; // Byte-write word

  pipelined_sync_sram_port pipelined_sync_sram_port_inst (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .select_first_n_i(ce1_n),
    .select_second_high_i(ce2), .select_third_n_i(ce3_n), .processor_addr_strobe_n_i(ps_n),
    .controller_addr_strobe_n_i(cs_n), .burst_advance_n_i(adv_n), .global_write_n_i(gw_n),
    .byte_write_enable_n_i(bwe_n), .byte_select_n_i(bsel_n), .output_enable_n_i(oe_n),
    .sleep_request_i(sleep), .burst_order_i(order), .data_i(wdata), .parity_lines_i(wpar),
    .data_o(data_o), .parity_lines_o(par_o), .data_oe_o(data_oe), .mem_rd_addr_o(rd_addr),
    .mem_rd_en_o(rd_en), .mem_rd_data_i(rd_data), .mem_rd_parity_i(rd_par), .mem_wr_valid_o(wr_valid),
    .mem_wr_ready_i(wr_ready), .mem_wr_addr_o(wr_addr), .mem_wr_data_o(wr_data), .mem_wr_parity_o(wr_par),
    .mem_wr_mask_o(wr_mask), .wr_buf_ready_o(buf_ready), .sleeping_o(sleeping));

  sram_array_model sram_array_model_inst (
    .core_clk_i(core_clk_i), .rd_addr_i(rd_addr), .rd_en_i(rd_en), .rd_data_o(rd_data),
    .rd_parity_o(rd_par), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .wr_parity_i(wr_par), .wr_mask_i(wr_mask), .stall_i(stall));

  // Clock at 100 MHz
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Expected initial array word of a location
  function automatic logic [31:0] pat(input logic [5:0] i);
    return {16'hC0DE, 10'h000, i};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Quiet bus: strobes off, device selected, no writes; sleep held low for normal use
  task automatic idle();
    {ps_n, cs_n, adv_n, gw_n, bwe_n, ce1_n, ce2, ce3_n, oe_n, sleep} = 10'b1111_1010_00;
    bsel_n = 4'hF;
  endtask

  task automatic do_reset(input logic ord);
    idle();
    order    = ord; // Strap held static from reset on
    arst_n_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
  endtask

  // Single processor-strobe read; float checks the masked first cycle
  task automatic rd(input logic [20:0] a, input logic [31:0] exp, input logic [3:0] ep, input logic float);
    ps_n = 1'b0;
    addr = a;
    @(negedge core_clk_i);
    ps_n = 1'b1;
    check("rd_en", rd_en, 1'b1);
    check("rd_addr", rd_addr, a);
    if (float)
      check("oe_first", data_oe, 1'b0);
    @(negedge core_clk_i);
    check("rd_data", data_o, exp);
    check("rd_par", par_o, ep);
    check("oe_drive", data_oe, 1'b1);
    oe_n = 1'b1;
    #1;
    check("oe_off", data_oe, 1'b0);
    oe_n = 1'b0;
  endtask

  task automatic t_reset();
    check("rst_oe", data_oe, 1'b0);
    check("rst_valid", wr_valid, 1'b0);
    check("rst_ready", buf_ready, 1'b1);
    check("rst_sleep", sleeping, 1'b0);
    rd(21'h3, pat(6'h3), 4'h3, 1'b1);
    $display("Test reset_and_read done");
  endtask

  // Non-selecting enable sets, then processor strobe with first enable high inside a burst
  task automatic t_desel();
    logic [2:0] combos [3] = '{3'b101, 3'b000, 3'b011};
    for (int i = 0; i < 3; i++)
    begin
      cs_n = 1'b0;
      {ce1_n, ce2, ce3_n} = combos[i];
      @(negedge core_clk_i);
      check("desel_en", rd_en, 1'b0);
    end
    {ce1_n, ce2, ce3_n} = 3'b010; // Selecting controller load opens a read burst
    addr = 21'h5;
    @(negedge core_clk_i);
    cs_n = 1'b1;
    ps_n = 1'b0;
    ce1_n = 1'b1;
    @(negedge core_clk_i);
    idle();
    check("ps_ignored", rd_en, 1'b1);
    check("ps_keep_addr", rd_addr, 21'h5);
    $display("Test deselect done");
  endtask

  // Both strobes with global write: processor strobe wins, so a read follows
  task automatic t_prio();
    {ps_n, cs_n, gw_n} = 3'b000;
    addr = 21'h7;
    @(negedge core_clk_i);
    idle();
    check("prio_rd", rd_en, 1'b1);
    check("prio_addr", rd_addr, 21'h7);
    @(negedge core_clk_i);
    check("prio_data", data_o, pat(6'h7));
    check("prio_nowr", wr_valid, 1'b0);
    $display("Test strobe_priority done");
  endtask

  // Global and byte writes into a stalled buffer, then drain and read back
  task automatic t_write();
    logic [31:0] p41;
    p41 = pat(6'd41);
    stall = 1'b1;
    oe_n  = 1'b1; // Master stops output drive before writing
    cs_n = 1'b0;
    gw_n = 1'b0;
    addr = 21'd40;
    wdata = D1;
    wpar = 4'hA;
    @(negedge core_clk_i);
    gw_n = 1'b1;
    bwe_n = 1'b0;
    bsel_n = 4'b1010;
    addr = 21'd41;
    wdata = D2;
    wpar = 4'h5;
    @(negedge core_clk_i);
    idle();
    oe_n = 1'b1;
    check("wr_valid", wr_valid, 1'b1);
    check("wr_addr", wr_addr, 21'd40);
    check("wr_data", wr_data, D1);
    check("wr_mask", wr_mask, 4'hF);
    repeat (2) @(negedge core_clk_i);
    check("buf_full", buf_ready, 1'b0);
    check("wr_hold", wr_addr, 21'd40);
    stall = 1'b0;
    for (int i = 0; i < 8 && wr_valid !== 1'b0; i++)
      @(negedge core_clk_i);
    check("drained", wr_valid, 1'b0);
    check("buf_free", buf_ready, 1'b1);
    oe_n = 1'b0;
    rd(21'd40, D1, 4'hA, 1'b0);
    rd(21'd41, {p41[31:24], D2[23:16], p41[15:8], D2[7:0]}, 4'b1101, 1'b0);
    $display("Test writes done");
  endtask

  // Processor-strobe write: write controls count only from the second edge
  task automatic t_pwrite();
    {ps_n, gw_n, oe_n} = 3'b001; // Output drive off before write data
    addr = 21'd42;
    wdata = D1;
    wpar = 4'h3;
    @(negedge core_clk_i);
    ps_n = 1'b1;
    wdata = D2;
    check("pw_first_rd", rd_en, 1'b1);
    @(negedge core_clk_i);
    idle();
    check("pw_float", data_oe, 1'b0);
    @(negedge core_clk_i);
    check("pw_addr", wr_addr, 21'd42);
    check("pw_data", wr_data, D2);
    rd(21'd42, D2, 4'h3, 1'b0);
    $display("Test processor_write done");
  endtask

  // Sleep blocks access, then contents survive
  task automatic t_sleep();
    sleep = 1'b1;
    for (int i = 0; i < 8 && sleeping !== 1'b1; i++)
      @(negedge core_clk_i);
    check("asleep", sleeping, 1'b1);
    ps_n = 1'b0;
    addr = 21'd3;
    @(negedge core_clk_i);
    ps_n = 1'b1;
    check("sleep_load", rd_en, 1'b0);
    @(negedge core_clk_i);
    check("sleep_rd", rd_en, 1'b0);
    sleep = 1'b0;
    for (int i = 0; i < 8 && sleeping !== 1'b0; i++)
      @(negedge core_clk_i);
    check("awake", sleeping, 1'b0);
    rd(21'd40, D1, 4'hA, 1'b1);
    $display("Test sleep done");
  endtask

  // Burst of six cycles with one held advance and enables dropped after the load
  task automatic t_burst(input logic ord, input logic [1:0] start);
    logic [1:0]  seq;
    logic [20:0] prev;
    int          n;
    n = 0;
    ps_n = 1'b0;
    addr = 21'h10 | start;
    @(negedge core_clk_i);
    ps_n = 1'b1;
    {ce1_n, ce2, ce3_n} = 3'b101; // Ignored on continuation edges
    for (int k = 1; k <= 6; k++)
    begin
      seq = ord ? start ^ n[1:0] : start + n[1:0];
      check("burst_addr", rd_addr, 21'h10 | seq);
      if (k > 1)
        check("burst_data", data_o, pat(prev[5:0]));
      prev = 21'h10 | seq;
      adv_n = (k == 3); // One held cycle re-reads
      if (k != 3)
        n++;
      @(negedge core_clk_i);
    end
    idle();
    $display("Test burst order %0d done", ord);
  endtask

  // Watchdog, well beyond the fewer than one hundred cycles the tests need
  initial
  begin
    #20000;
    err_count++;
    end_of_test();
  end

  initial
  begin
    err_count = 0;
    total_checks = 0;
    addr = '0;
    wdata = '0;
    wpar = '0;
    stall = 1'b0;
    do_reset(1'b1);
    t_reset();
    t_desel();
    t_prio();
    t_write();
    t_pwrite();
    t_sleep();
    t_burst(1'b1, 2'd1);
    do_reset(1'b0);
    t_burst(1'b0, 2'd2);
    end_of_test();
  end
endmodule

`default_nettype wire
